/* verilog/ycf_pkg.sv */
// Overview of operation
// - Writing 0 to run bit lets the current frame finish, then capture stops.
// - Writing 1 to run bit starts capture only at the next frame start.
// - Continuous capture takes one frame and skips the next, alternately.
// - Threshold 00 never triggers, 01 reserved, 10 between quarter and half, 11 above half.
// - A met threshold condition sets the threshold trigger status flag.
// - Writing 0 to the FIFO clear bit changes nothing.
// - Writing 1 to the clear bit empties FIFO, pointers and valid size.
// - A FIFO clear leaves the raw empty flag unchanged.
// - Read-only direction bit reads 0 for camera receive operation.
// - Direction bit 1 means transmit, host data flows through the FIFO.
// - FIFO size is the size field plus seven, in four-byte units.
package ycf_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int PIX_W = 16;
    localparam int CNT_W = 9;
    localparam int FIFO_DEPTH = 262;
    localparam logic [13:0] IDX_RSVD_A = 14'h2808;
    localparam logic [13:0] IDX_RUN = 14'h280a;
    localparam logic [13:0] IDX_RSVD_B = 14'h280c;
    localparam logic [13:0] IDX_RSVD_C = 14'h280e;
    localparam logic [13:0] IDX_FCTRL = 14'h2820;
    localparam logic [13:0] IDX_SIZE = 14'h2824;
    localparam logic [13:0] IDX_STAT = 14'h2830;
    localparam logic [13:0] IDX_MASK = 14'h2831;
    localparam logic [13:0] IDX_LEVEL = 14'h2832;
    localparam int RUN_BIT = 0;
    localparam int DIR_BIT = 0;
    localparam int CLR_BIT = 2;
    localparam int THR_LSB = 4;
    localparam int LVL_GATE_LSB = 16;
    localparam logic [1:0] THR_NEVER = 2'h0;
    localparam logic [1:0] THR_RSVD = 2'h1;
    localparam logic [1:0] THR_QTR = 2'h2;
    localparam logic [1:0] THR_HALF = 2'h3;
    localparam logic [1:0] THR_RST = 2'h0;
    localparam logic [7:0] SIZE_RST = 8'h3f;
    localparam logic [CNT_W-1:0] SIZE_ADD = 9'h007;
    localparam logic [CNT_W-1:0] RAW_EMPTY_DW = 9'h002;
    localparam int ST_W = 3;
    localparam int ST_EMPTY = 0;
    localparam int ST_FULL = 1;
    localparam int ST_THR = 2;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } ycf_apb_req_t;

    typedef struct packed {
        logic vsync;
        logic href;
        logic [PIX_W-1:0] pix;
    } ycf_cam_t;

    typedef enum logic [1:0] {
        GS_IDLE = 2'b00,
        GS_ARMED = 2'b01,
        GS_CAPTURE = 2'b10,
        GS_SKIP = 2'b11
    } ycf_gate_state_t;
endpackage

/* verilog/ycf_frame_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module ycf_frame_gate (
    input wire logic mclk,
    input wire logic reset,
    input wire logic softReset,
    input wire logic frameStart,
    input wire logic runWr,
    input wire logic runVal,
    output logic capturing,
    output ycf_pkg::ycf_gate_state_t gateState
);
    import ycf_pkg::*;

    typedef struct packed {
        ycf_gate_state_t st;
        logic runReq;
    } ycf_gate_reg_t;

    ycf_gate_reg_t s_r;
    ycf_gate_reg_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (runWr)
            s_nxt.runReq = runVal;
        // Capture and skip change only at a frame boundary or a soft reset; arming and disarming follow run at once
        case (s_r.st)
            GS_IDLE: begin
                if (s_nxt.runReq)
                    s_nxt.st = GS_ARMED;
            end
            GS_ARMED: begin
                if (!s_nxt.runReq)
                    s_nxt.st = GS_IDLE;
                else if (frameStart)
                    s_nxt.st = GS_CAPTURE;
            end
            GS_CAPTURE: begin
                if (frameStart)
                    s_nxt.st = s_nxt.runReq ? GS_SKIP : GS_IDLE;
            end
            GS_SKIP: begin
                if (frameStart)
                    s_nxt.st = s_nxt.runReq ? GS_CAPTURE : GS_IDLE;
            end
            default: s_nxt.st = GS_IDLE;
        endcase
        if (softReset) begin
            s_nxt.st = GS_IDLE;
            s_nxt.runReq = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            s_r <= '{st: GS_IDLE, runReq: 1'b0};
        else
            s_r <= s_nxt;
    end

    assign capturing = (s_r.st == GS_CAPTURE);
    assign gateState = s_r.st;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_start_on_boundary: assert property ($rose(capturing) |-> $past(frameStart))
        else $error("capture began away from a frame start");
    a_stop_frame_end: assert property (capturing && !frameStart && !softReset |=> capturing)
        else $error("capture ended inside a frame");
    a_skip_alternate: assert property (capturing && frameStart |=> !capturing)
        else $error("two frames captured back to back");
    c_capture_frame: cover property (frameStart ##1 capturing);
endmodule
`default_nettype wire

/* verilog/ycf_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module ycf_fifo #(
    parameter int DEPTH = 262,
    parameter int WIDTH = 32,
    parameter int CW = 9
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clear,
    input wire logic push,
    input wire logic [WIDTH-1:0] pushData,
    input wire logic pop,
    input wire logic [CW-1:0] limit,
    output logic [WIDTH-1:0] rdData,
    output logic [CW-1:0] count,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 8 || DEPTH > (1 << CW) - 1) begin : g_chk
        $error("ycf_fifo depth out of range");
    end

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } ycf_fifo_reg_t;

    ycf_fifo_reg_t s_r;
    ycf_fifo_reg_t s_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic doPush;
    logic doPop;

    assign full = (s_r.cnt >= limit) || (s_r.cnt == CW'(DEPTH));
    assign empty = (s_r.cnt == '0);
    assign doPush = push && !full;
    assign doPop = pop && !empty;

    always_comb begin
        s_nxt = s_r;
        if (doPush)
            s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
        if (doPop)
            s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
        if (doPush && !doPop)
            s_nxt.cnt = s_r.cnt + 1'b1;
        else if (doPop && !doPush)
            s_nxt.cnt = s_r.cnt - 1'b1;
        if (clear)
            s_nxt = '0;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    always_ff @(posedge mclk) begin
        if (doPush && !clear)
            mem[s_r.wp] <= pushData;
    end

    assign rdData = mem[s_r.rp];
    assign count = s_r.cnt;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_clear_empties: assert property (clear |=> count == '0 && empty)
        else $error("clear left data in the fifo");
    a_push_counts: assert property (doPush && !doPop && !clear |=> count == $past(count) + 1'b1)
        else $error("push not counted");
endmodule
`default_nettype wire

/* verilog/ycf_capture_fifo_ctrl.sv */
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ycf_capture_fifo_ctrl #(
    parameter int DEPTH = ycf_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic reset,
    input wire ycf_pkg::ycf_apb_req_t apbReq,
    output logic [ycf_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ycf_pkg::ycf_cam_t cam,
    input wire logic dirTx,
    input wire logic softReset,
    input wire logic hostValid,
    input wire logic [ycf_pkg::DATA_W-1:0] hostData,
    output logic hostReady,
    input wire logic memReady,
    output logic memValid,
    output logic [ycf_pkg::DATA_W-1:0] memData,
    output logic captureActive,
    output logic irq
);
    import ycf_pkg::*;

    if (DEPTH < 8 || DEPTH > (1 << CNT_W) - 1) begin : g_chk
        $error("ycf_capture_fifo_ctrl depth out of range");
    end

    typedef struct packed {
        logic vs1;
        logic vs2;
        logic vs3;
        logic hr1;
        logic hr2;
        logic [PIX_W-1:0] pd1;
        logic [PIX_W-1:0] pd2;
        logic dir1;
        logic dir2;
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
        logic [1:0] thr;
        logic [7:0] size;
        logic [ST_W-1:0] stat;
        logic [ST_W-1:0] mask;
        logic irq;
        logic runWr;
        logic runVal;
        logic clr;
        logic half;
        logic [PIX_W-1:0] lowPix;
        logic memValid;
        logic [DATA_W-1:0] memData;
        logic hostReady;
        logic fullD;
        logic capD;
    } ycf_main_reg_t;

    localparam ycf_main_reg_t MAIN_RST = '{thr: THR_RST, size: SIZE_RST, default: '0};

    ycf_main_reg_t s_r;
    ycf_main_reg_t s_nxt;

    logic frameStart;
    logic capturing;
    ycf_gate_state_t gateState;
    logic fifoClear;
    logic fifoPush;
    logic fifoPop;
    logic camPush;
    logic [DATA_W-1:0] pushData;
    logic [DATA_W-1:0] fifoRd;
    logic [CNT_W-1:0] fifoCount;
    logic fifoFull;
    logic fifoEmpty;
    logic [CNT_W-1:0] sizeDw;
    logic [CNT_W-1:0] capDw;
    logic [CNT_W+1:0] cnt4;
    logic [CNT_W+1:0] cnt2;
    logic [CNT_W+1:0] sz;
    logic thrEv;
    logic emptyEv;
    logic fullEv;
    logic setup;
    logic access;
    logic [13:0] idx;
    logic wrOk;

    // Frame start is the rising edge of the synchronised frame sync
    assign frameStart = s_r.vs2 & ~s_r.vs3;

    // Capacity in dwords, clamped to the storage actually built
    assign sizeDw = CNT_W'({1'b0, s_r.size}) + SIZE_ADD;
    assign capDw = (sizeDw > CNT_W'(DEPTH)) ? CNT_W'(DEPTH) : sizeDw;

    // Exact fractions without truncation: 4*count vs size, 2*count vs size
    assign cnt4 = {fifoCount, 2'b00};
    assign cnt2 = {1'b0, fifoCount, 1'b0};
    assign sz = {2'b00, sizeDw};

    always_comb begin
        case (s_r.thr)
            THR_QTR: thrEv = (cnt4 > sz) && (cnt2 < sz);
            THR_HALF: thrEv = cnt2 > sz;
            default: thrEv = 1'b0;
        endcase
    end

    // Camera words pair two pixels, first pixel in the low half
    assign camPush = capturing && !s_r.dir2 && s_r.hr2 && s_r.half;
    assign fifoPush = s_r.dir2 ? (hostValid && s_r.hostReady) : camPush;
    assign pushData = s_r.dir2 ? hostData : {s_r.pd2, s_r.lowPix};
    assign fifoClear = s_r.clr | softReset;
    assign fifoPop = !fifoEmpty && (!s_r.memValid || memReady) && !fifoClear;

    // Raw empty is raised only by draining, so a clear never touches it
    assign emptyEv = fifoPop && (fifoCount == RAW_EMPTY_DW);
    assign fullEv = fifoFull && !s_r.fullD;

    assign idx = apbReq.paddr[ADDR_W-1:2];
    assign setup = apbReq.psel && !apbReq.penable && !s_r.pready;
    assign access = apbReq.psel && apbReq.penable && s_r.pready;
    assign wrOk = access && apbReq.pwrite && !s_r.pslverr;

    always_comb begin
        logic [DATA_W-1:0] rdVal;
        logic rdHit;
        logic [ST_W-1:0] w1c;
        rdVal = '0;
        rdHit = 1'b1;
        w1c = '0;
        s_nxt = s_r;

        s_nxt.vs1 = cam.vsync;
        s_nxt.vs2 = s_r.vs1;
        s_nxt.vs3 = s_r.vs2;
        s_nxt.hr1 = cam.href;
        s_nxt.hr2 = s_r.hr1;
        s_nxt.pd1 = cam.pix;
        s_nxt.pd2 = s_r.pd1;
        s_nxt.dir1 = dirTx;
        s_nxt.dir2 = s_r.dir1;

        s_nxt.runWr = 1'b0;
        s_nxt.clr = 1'b0;
        s_nxt.pready = setup;

        case (idx)
            IDX_RUN, IDX_RSVD_A, IDX_RSVD_B, IDX_RSVD_C: rdVal = '0;
            IDX_FCTRL: begin
                rdVal[THR_LSB +: 2] = s_r.thr;
                rdVal[DIR_BIT] = s_r.dir2;
            end
            IDX_SIZE: rdVal[7:0] = s_r.size;
            IDX_STAT: rdVal[ST_W-1:0] = s_r.stat;
            IDX_MASK: rdVal[ST_W-1:0] = s_r.mask;
            IDX_LEVEL: begin
                rdVal[CNT_W-1:0] = fifoCount;
                rdVal[LVL_GATE_LSB +: 2] = gateState;
            end
            default: rdHit = 1'b0;
        endcase

        if (setup) begin
            s_nxt.prdata = apbReq.pwrite ? '0 : rdVal;
            s_nxt.pslverr = !rdHit || (apbReq.paddr[1:0] != 2'b00);
        end

        if (wrOk) begin
            case (idx)
                IDX_RUN: begin
                    s_nxt.runWr = 1'b1;
                    s_nxt.runVal = apbReq.pwdata[RUN_BIT];
                end
                IDX_FCTRL: begin
                    s_nxt.thr = apbReq.pwdata[THR_LSB +: 2];
                    s_nxt.clr = apbReq.pwdata[CLR_BIT];
                end
                IDX_SIZE: s_nxt.size = apbReq.pwdata[7:0];
                IDX_STAT: w1c = apbReq.pwdata[ST_W-1:0];
                IDX_MASK: s_nxt.mask = apbReq.pwdata[ST_W-1:0];
                // Reserved locations accept and drop writes
                default: s_nxt.thr = s_r.thr;
            endcase
        end

        // Sticky flags: a new event wins over a same-cycle clear
        s_nxt.stat = s_r.stat & ~w1c;
        if (emptyEv)
            s_nxt.stat[ST_EMPTY] = 1'b1;
        if (fullEv)
            s_nxt.stat[ST_FULL] = 1'b1;
        if (thrEv)
            s_nxt.stat[ST_THR] = 1'b1;
        s_nxt.irq = |(s_nxt.stat & s_nxt.mask);

        // Pixel pairing restarts at each frame
        if (frameStart || softReset)
            s_nxt.half = 1'b0;
        else if (capturing && !s_r.dir2 && s_r.hr2) begin
            s_nxt.half = !s_r.half;
            if (!s_r.half)
                s_nxt.lowPix = s_r.pd2;
        end

        // One-word output stage toward memory
        if (fifoClear)
            s_nxt.memValid = 1'b0;
        else if (fifoPop) begin
            s_nxt.memValid = 1'b1;
            s_nxt.memData = fifoRd;
        end else if (memReady)
            s_nxt.memValid = 1'b0;

        // Margin of two keeps a one-cycle-late ready from overfilling
        s_nxt.hostReady = s_r.dir2 && !fifoClear && (({1'b0, fifoCount} + 10'h002) < {1'b0, capDw});
        s_nxt.fullD = fifoFull;
        s_nxt.capD = capturing;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            s_r <= MAIN_RST;
        else
            s_r <= s_nxt;
    end

    ycf_frame_gate u_gate (
        .mclk(mclk),
        .reset(reset),
        .softReset(softReset),
        .frameStart(frameStart),
        .runWr(s_r.runWr),
        .runVal(s_r.runVal),
        .capturing(capturing),
        .gateState(gateState)
    );

    ycf_fifo #(
        .DEPTH(DEPTH),
        .WIDTH(DATA_W),
        .CW(CNT_W)
    ) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .clear(fifoClear),
        .push(fifoPush),
        .pushData(pushData),
        .pop(fifoPop),
        .limit(capDw),
        .rdData(fifoRd),
        .count(fifoCount),
        .full(fifoFull),
        .empty(fifoEmpty)
    );

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign hostReady = s_r.hostReady;
    assign memValid = s_r.memValid;
    assign memData = s_r.memData;
    assign captureActive = s_r.capD;
    assign irq = s_r.irq;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_thr_never: assert property ((s_r.thr == THR_NEVER || s_r.thr == THR_RSVD) |-> !thrEv)
        else $error("threshold fired with a non-triggering code");
    a_thr_flag_set: assert property (thrEv |=> s_r.stat[ST_THR])
        else $error("threshold event not latched");
    a_clr_zero_noop: assert property (wrOk && idx == IDX_FCTRL && !apbReq.pwdata[CLR_BIT] |=> !s_r.clr)
        else $error("clear raised by writing zero");
    a_clr_empties: assert property (wrOk && idx == IDX_FCTRL && apbReq.pwdata[CLR_BIT]
        |=> s_r.clr ##1 (fifoCount == '0 && !s_r.memValid))
        else $error("clear did not empty the fifo");
    a_raw_empty_kept: assert property (s_r.clr && !s_r.stat[ST_EMPTY] && !emptyEv |=> !s_r.stat[ST_EMPTY])
        else $error("clear disturbed the raw empty flag");
    a_dir_report: assert property (setup && !apbReq.pwrite && idx == IDX_FCTRL
        |=> s_r.prdata[DIR_BIT] == $past(s_r.dir2))
        else $error("direction bit misreported");
    a_irq_level: assert property (s_r.irq == |(s_r.stat & s_r.mask))
        else $error("interrupt level disagrees with status and mask");
    c_thr_hit: cover property (thrEv ##1 s_r.irq);
    c_clear_seen: cover property (s_r.clr ##1 fifoCount == '0);
    c_host_stall: cover property (hostValid && !s_r.hostReady && s_r.dir2);
endmodule
`default_nettype wire

/* bench/ycf_cam_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ycf_cam_model #(
    parameter int NPIX = 4
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic go,
    input wire logic [7:0] frameId,
    output var ycf_pkg::ycf_cam_t cam,
    output logic busy
);
    import ycf_pkg::*;
    int cyc;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cam <= '0;
            busy <= 1'b0;
            cyc <= 0;
        end else if (busy) begin
            cyc <= cyc + 1;
            cam.vsync <= (cyc < 4);
            cam.href <= (cyc >= 8 && cyc < 8 + NPIX);
            // Pixel value names frame and position; idle data keeps toggling
            if (cyc >= 8 && cyc < 8 + NPIX) begin
                cam.pix <= {frameId, 8'(cyc - 8)};
            end else begin
                cam.pix <= ~cam.pix;
            end
            if (cyc == 12 + NPIX) begin
                busy <= 1'b0;
            end
        end else begin
            cam.pix <= ~cam.pix;
            if (go) begin
                busy <= 1'b1;
                cyc <= 0;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ycf_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    ycf_apb_req_t apbReq = '0;
    ycf_cam_t cam;
    logic [DATA_W-1:0] prdata, memData, rd;
    logic [DATA_W-1:0] hostData = '0;
    logic pready, pslverr, hostReady, memValid, captureActive, irq, camBusy, err;
    logic dirTx = 1'b0;
    logic softReset = 1'b0;
    logic hostValid = 1'b0;
    logic memReady = 1'b1;
    logic camGo = 1'b0;
    logic [7:0] camId = '0;
    logic [DATA_W-1:0] words[$];
    int errCount = 0;
    int samplesChecked = 0;
    logic [1:0] codes[6] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1};
    int pushes[6] = '{5, 3, 4, 4, 5, 5};
    logic exps[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

    always #12.5 mclk = ~mclk;

    ycf_capture_fifo_ctrl #(.DEPTH(16)) dut_u (.mclk(mclk), .reset(reset), .apbReq(apbReq), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cam(cam), .dirTx(dirTx), .softReset(softReset),
        .hostValid(hostValid), .hostData(hostData), .hostReady(hostReady), .memReady(memReady),
        .memValid(memValid), .memData(memData), .captureActive(captureActive), .irq(irq));

    ycf_cam_model #(.NPIX(4)) cam_u (.mclk(mclk), .reset(reset), .go(camGo), .frameId(camId),
        .cam(cam), .busy(camBusy));

    always @(posedge mclk) begin
        if (memValid === 1'b1 && memReady === 1'b1) begin
            words.push_back(memData);
        end
    end

    task giveVerdict;
        if (errCount == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task timeout;
        errCount++;
        giveVerdict();
    endtask

    task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [13:0] idx, input logic [DATA_W-1:0] wd);
        int n;
        @(posedge mclk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
        @(posedge mclk);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (n > 20) timeout();
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    // One camera frame; optional run write lands after frame start, before pixels
    task frame(input logic [7:0] id, input logic doRun, input logic runVal);
        int n;
        camId <= id;
        camGo <= 1'b1;
        @(posedge mclk);
        camGo <= 1'b0;
        repeat (4) @(posedge mclk);
        if (doRun) apb(1'b1, IDX_RUN, {31'h0, runVal});
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (n > 100) timeout();
        end while (camBusy !== 1'b0);
        repeat (4) @(posedge mclk);
    endtask

    task push(input logic [DATA_W-1:0] d);
        int n;
        hostValid <= 1'b1;
        hostData <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (n > 50) timeout();
        end while (hostReady !== 1'b1);
        hostValid <= 1'b0;
        @(posedge mclk);
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        apb(1'b0, IDX_FCTRL, '0);
        check(rd, 32'h0);
        apb(1'b0, IDX_SIZE, '0);
        check(rd, {24'h0, SIZE_RST});
        apb(1'b0, 14'h2900, '0);
        check({31'h0, err}, 32'h1);
        apb(1'b0, IDX_RSVD_A, '0);
        check({rd[30:0], err}, 32'h0);
        // Start mid-frame, capture, skip, capture with stop mid-frame, then idle
        frame(8'h00, 1'b1, 1'b1);
        frame(8'h01, 1'b0, 1'b0);
        check({31'h0, captureActive}, 32'h1);
        frame(8'h02, 1'b0, 1'b0);
        frame(8'h03, 1'b1, 1'b0);
        frame(8'h04, 1'b0, 1'b0);
        frame(8'h05, 1'b0, 1'b0);
        check({31'h0, captureActive}, 32'h0);
        check(32'(words.size()), 32'h4);
        for (int i = 0; i < 4; i++) begin
            check(words[i], {8'(i < 2 ? 1 : 3), 8'(2 * (i % 2) + 1), 8'(i < 2 ? 1 : 3), 8'(2 * (i % 2))});
        end
        // Transmit mode, size 8 dwords, threshold interrupt unmasked
        dirTx <= 1'b1;
        memReady <= 1'b0;
        apb(1'b1, IDX_SIZE, 32'h1);
        apb(1'b1, IDX_MASK, 32'h4);
        apb(1'b0, IDX_FCTRL, '0);
        check(rd, 32'h1);
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, IDX_FCTRL, 32'h4);
            repeat (3) @(posedge mclk);
            apb(1'b0, IDX_LEVEL, '0);
            check({23'h0, rd[8:0]}, 32'h0);
            apb(1'b0, IDX_STAT, '0);
            check({31'h0, rd[ST_EMPTY]}, 32'h0);
            apb(1'b0, IDX_LEVEL, '0);
            apb(1'b0, IDX_LEVEL, '0);
            softReset <= 1'b1;
            @(posedge mclk);
            softReset <= 1'b0;
            // One extra word parks in the stalled output stage
            for (int j = 0; j <= pushes[k]; j++) push(32'h1000 + j);
            apb(1'b1, IDX_FCTRL, 32'h0);
            apb(1'b0, IDX_LEVEL, '0);
            check({23'h0, rd[8:0]}, 32'(pushes[k]));
            apb(1'b1, IDX_STAT, 32'h7);
            apb(1'b1, IDX_FCTRL, {26'h0, codes[k], 4'h0});
            repeat (3) @(posedge mclk);
            apb(1'b0, IDX_STAT, '0);
            check({31'h0, rd[ST_THR]}, {31'h0, exps[k]});
            check({31'h0, irq}, {31'h0, exps[k]});
        end
        giveVerdict();
    end
endmodule
`default_nettype wire
